// File: core/dac_ctrl_pkg.sv
// Purpose: Shared constants and types for the quad converter load and clear control
// Assumes: Serial word of 24 bits; four channels of 16-bit codes
// Notes:   Word layout of the low bits is a simple address plus data split
package dac_ctrl_pkg;
	localparam int             WORD_BITS   = 24;
	localparam int             CODE_BITS   = 16;
	localparam int             CHAN_COUNT  = 4;
	localparam int             ADDR_LSB    = 16;
	localparam int             ADDR_BITS   = 2;
	localparam int             CNT_BITS    = 5;
	localparam logic [15:0]    RESET_CODE  = 16'h0000;
	localparam logic [15:0]    ZERO_CODE   = 16'h0000;
	localparam logic [15:0]    MID_CODE    = 16'h8000;
	localparam logic [4:0]     WORD_COUNT  = 5'h18;

	// Synchronised serial link, load and clear pin levels
	typedef struct packed {
		logic frame_n;
		logic sclk;
		logic serial_in;
		logic load_n;
		logic clear_n;
	} pins_type;

	typedef logic [CHAN_COUNT-1:0][CODE_BITS-1:0] bank_type;
endpackage

// File: core/dac_load_clear.sv
// Purpose: Serial word capture, input and output register banks, load and clear control
// Assumes: All pins are asynchronous to clk_sys_i and are sampled through two flip-flops
// Notes:   Serial clock edges are found from sampled levels; sclk must be slow vs clk_sys_i
//
// Contract
// - Load strobe low: addressed output register updates at frame-select rising edge.
// - Load strobe high through frame: only the input register takes the word.
// - Pending input values move to outputs only on load strobe falling edge.
// - One load strobe falling edge moves all four channels together.
// - Clear low loads output registers with zero or midscale, per clear setting.
// - Shift register contents go out on serial_out for chaining or readback.
// - Serial out changes on sclk rising edge; host samples on falling edge.
// - Frame-select low for transfer; bit in on each sclk fall; latch at frame end.
// - A write frame of 24 or more bits yields one 24-bit word, its last 24 bits.
// - After reset all output registers hold 0x0000 until written.
module dac_load_clear (
	// Clock and reset
	input  wire logic                           clk_sys_i,
	input  wire logic                           rst_i,
	// Serial link pins
	input  wire logic                           frame_n_i,
	input  wire logic                           sclk_i,
	input  wire logic                           serial_in_i,
	output logic                                serial_out_o,
	// Update and clear pins
	input  wire logic                           output_load_strobe_n_i,
	input  wire logic                           scale_reset_n_i,
	input  wire logic                           clear_mid_i,
	// Converter codes
	output dac_ctrl_pkg::bank_type              dac_code_o
);
	//--------------------------------------------------------------
	// Input synchronisers
	//--------------------------------------------------------------
	dac_ctrl_pkg::pins_type meta;
	dac_ctrl_pkg::pins_type pins;
	dac_ctrl_pkg::pins_type pins_d;
	logic                   mid_meta;
	logic                   mid_sel;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			meta         <= '{frame_n: 1'b1, sclk: 1'b0, serial_in: 1'b0, load_n: 1'b1, clear_n: 1'b1};
			pins         <= '{frame_n: 1'b1, sclk: 1'b0, serial_in: 1'b0, load_n: 1'b1, clear_n: 1'b1};
			pins_d       <= '{frame_n: 1'b1, sclk: 1'b0, serial_in: 1'b0, load_n: 1'b1, clear_n: 1'b1};
			mid_meta     <= 1'b0;
			mid_sel      <= 1'b0;
		end else begin
			meta         <= '{frame_n: frame_n_i, sclk: sclk_i, serial_in: serial_in_i,
				load_n: output_load_strobe_n_i, clear_n: scale_reset_n_i};
			pins         <= meta;
			pins_d       <= pins;
			mid_meta     <= clear_mid_i;
			mid_sel      <= mid_meta;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic frame_end;
	logic load_fall;
	logic in_frame;

	assign sclk_rise = pins.sclk & ~pins_d.sclk;
	assign sclk_fall = ~pins.sclk & pins_d.sclk;
	assign frame_end = pins.frame_n & ~pins_d.frame_n;
	assign load_fall = ~pins.load_n & pins_d.load_n;
	assign in_frame  = ~pins.frame_n;

	//--------------------------------------------------------------
	// Serial shift register
	//--------------------------------------------------------------
	logic [dac_ctrl_pkg::WORD_BITS-1:0] shift;
	logic [dac_ctrl_pkg::WORD_BITS-1:0] next_shift;
	logic [dac_ctrl_pkg::CNT_BITS-1:0]  bit_cnt;
	logic [dac_ctrl_pkg::CNT_BITS-1:0]  next_bit_cnt;
	logic                               sout;
	logic                               next_sout;
	logic                               held_high;
	logic                               next_held_high;

	always_comb begin
		next_shift     = shift;
		next_bit_cnt   = bit_cnt;
		next_sout      = sout;
		next_held_high = held_high;
		if (in_frame && sclk_fall) begin
			next_shift = {shift[dac_ctrl_pkg::WORD_BITS-2:0], pins.serial_in};
			if (bit_cnt != dac_ctrl_pkg::WORD_COUNT) begin
				next_bit_cnt = bit_cnt + 5'h01;
			end
		end
		if (in_frame && sclk_rise) begin
			next_sout = shift[dac_ctrl_pkg::WORD_BITS-1];
		end
		if (in_frame && !pins.load_n) begin
			next_held_high = 1'b0;
		end
		if (frame_end) begin
			next_bit_cnt   = '0;
			next_held_high = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			shift     <= '0;
			bit_cnt   <= '0;
			sout      <= 1'b0;
			held_high <= 1'b1;
		end else begin
			shift     <= next_shift;
			bit_cnt   <= next_bit_cnt;
			sout      <= next_sout;
			held_high <= next_held_high;
		end
	end

	assign serial_out_o = sout;

	//--------------------------------------------------------------
	// Input and output register banks
	//--------------------------------------------------------------
	dac_ctrl_pkg::bank_type                input_bank;
	dac_ctrl_pkg::bank_type                next_input_bank;
	dac_ctrl_pkg::bank_type                next_dac_code;
	logic [dac_ctrl_pkg::ADDR_BITS-1:0]    addr;
	logic [dac_ctrl_pkg::CODE_BITS-1:0]    data;
	logic                                  word_ok;
	logic                                  hold_mode;

	assign addr      = shift[dac_ctrl_pkg::ADDR_LSB +: dac_ctrl_pkg::ADDR_BITS];
	assign data      = shift[dac_ctrl_pkg::CODE_BITS-1:0];
	assign word_ok   = frame_end && (bit_cnt == dac_ctrl_pkg::WORD_COUNT);
	// Strobe high for the whole frame defers the output update
	assign hold_mode = held_high && pins.load_n;

	always_comb begin
		next_input_bank = input_bank;
		next_dac_code   = dac_code_o;
		if (word_ok) begin
			next_input_bank[addr] = data;
			if (!hold_mode) begin
				next_dac_code[addr] = data;
			end
		end
		if (load_fall) begin
			next_dac_code = next_input_bank;
		end
		if (!pins.clear_n) begin
			for (int i = 0; i < dac_ctrl_pkg::CHAN_COUNT; i++) begin
				next_dac_code[i] = mid_sel ? dac_ctrl_pkg::MID_CODE
					: dac_ctrl_pkg::ZERO_CODE;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			input_bank <= {dac_ctrl_pkg::CHAN_COUNT{dac_ctrl_pkg::RESET_CODE}};
			dac_code_o <= {dac_ctrl_pkg::CHAN_COUNT{dac_ctrl_pkg::RESET_CODE}};
		end else begin
			input_bank <= next_input_bank;
			dac_code_o <= next_dac_code;
		end
	end

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	sequence word_done_s;
		word_ok && !hold_mode && pins.clear_n;
	endsequence

	sequence strobe_fall_s;
		load_fall && !word_ok && pins.clear_n;
	endsequence

	direct_update_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		word_done_s |=> dac_code_o[$past(addr)] == $past(data))
		else $error("Direct update missed");
	held_update_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(word_ok && hold_mode && !load_fall && pins.clear_n) |=> $stable(dac_code_o))
		else $error("Held word reached output");
	input_store_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		word_ok |=> input_bank[$past(addr)] == $past(data))
		else $error("Input register not written");
	strobe_only_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(!load_fall && !word_ok && pins.clear_n) |=> $stable(dac_code_o))
		else $error("Output changed without cause");
	all_channels_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		strobe_fall_s |=> dac_code_o == input_bank)
		else $error("Simultaneous transfer failed");
	clear_code_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(!pins.clear_n && !mid_sel) |=> dac_code_o == '0)
		else $error("Clear code wrong");
	clear_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(!pins.clear_n && mid_sel)[*2] |=> dac_code_o[0] == dac_ctrl_pkg::MID_CODE)
		else $error("Midscale clear not held");
	sout_edge_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$changed(serial_out_o) |-> $past(sclk_rise))
		else $error("Serial out changed off rising edge");
	shift_in_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(in_frame && sclk_fall) |=> shift[0] == $past(pins.serial_in))
		else $error("Bit not shifted in");
	bit_count_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		frame_end |=> bit_cnt == '0)
		else $error("Bit counter not cleared");
	reset_val_a: assert property (@(posedge clk_sys_i)
		rst_i |=> dac_code_o == '0)
		else $error("Reset value wrong");
	sout_src_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(in_frame && sclk_rise) |=> serial_out_o == $past(shift[dac_ctrl_pkg::WORD_BITS-1]))
		else $error("Serial out not from shift register");
	short_frame_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(frame_end && (bit_cnt != dac_ctrl_pkg::WORD_COUNT)) |=> $stable(input_bank))
		else $error("Short frame was stored");
	sout_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!in_frame |=> $stable(serial_out_o))
		else $error("Serial out changed outside frame");
endmodule

// File: tb/host_master.sv
// Purpose: Serial master model driving frame select, link clock and data
// Assumes: Tasks are entered at a falling clk_sys_i edge
// Notes:   Link clock stands still low outside frames
module host_master (
	// Link pins
	output logic     frame_n_o,
	output logic     sclk_o,
	output logic     serial_in_o,
	input wire logic serial_out_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		frame_n_o = 1'b1;
		sclk_o = 1'b0;
		serial_in_o = 1'b0;
	end
	// Sends n bits of w MSB first, returns what came back
	task automatic send(input logic [23:0] w, input int n, output logic [23:0] got);
		got = 24'h000000;
		frame_n_o = 1'b0;
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			sclk_o = 1'b1;
			serial_in_o = w[i];
			#40;
			sclk_o = 1'b0;
			got = {got[22:0], serial_out_i};
			#40;
		end
		frame_n_o = 1'b1;
		serial_in_o = ~serial_in_o;
		#40;
	endtask
endmodule

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the load and clear control
// Assumes: Inputs change at falling clk_sys_i edges
// Notes:   Outputs are checked 8 clocks after each cause
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic load_n = 1'b0;
	logic clear_n = 1'b1;
	logic clear_mid = 1'b0;
	logic frame_n, sclk, serial_in, serial_out;
	logic [23:0] got;
	dac_ctrl_pkg::bank_type dac_code;
	int errors = 0;
	int checked = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	host_master i_host_master (.frame_n_o(frame_n), .sclk_o(sclk), .serial_in_o(serial_in),
		.serial_out_i(serial_out));
	dac_load_clear i_dac_load_clear (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.frame_n_i(frame_n), .sclk_i(sclk), .serial_in_i(serial_in), .serial_out_o(serial_out),
		.output_load_strobe_n_i(load_n), .scale_reset_n_i(clear_n),
		.clear_mid_i(clear_mid), .dac_code_o(dac_code));
	task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string m);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic check_bank(input logic [63:0] exp, input string m);
		wait_clk(8);
		for (int c = 0; c < 4; c++) begin
			check({8'h00, dac_code[c]}, {8'h00, exp[c*16 +: 16]}, m);
		end
	endtask
	task automatic test_direct;
		check_bank(64'h0, "reset bank");
		load_n = 1'b0;
		i_host_master.send(24'h021234, 24, got);
		check_bank(64'h0000_1234_0000_0000, "direct update");
		i_host_master.send(24'hffabcd, 24, got);
		check(got, 24'h021234, "readback");
		check_bank(64'habcd_1234_0000_0000, "second update");
		i_host_master.send(24'h000555, 23, got);
		check_bank(64'habcd_1234_0000_0000, "short frame");
		$display("test direct done");
	endtask
	task automatic test_hold;
		load_n = 1'b1;
		for (int c = 0; c < 4; c++) begin
			i_host_master.send({6'h00, c[1:0], {4{c[3:0] + 4'h1}}}, 24, got);
		end
		check_bank(64'habcd_1234_0000_0000, "held update");
		load_n = 1'b0;
		check_bank(64'h4444_3333_2222_1111, "strobe fall");
		$display("test hold done");
	endtask
	task automatic test_clear;
		clear_mid = 1'b1;
		clear_n = 1'b0;
		check_bank({4{16'h8000}}, "mid clear");
		i_host_master.send(24'h017777, 24, got);
		check_bank({4{16'h8000}}, "clear held");
		clear_mid = 1'b0;
		check_bank(64'h0, "zero clear");
		clear_n = 1'b1;
		$display("test clear done");
	endtask
	initial begin
		wait_clk(20);
		rst_i = 1'b0;
		wait_clk(4);
		test_direct();
		test_hold();
		test_clear();
		end_of_test();
	end
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule
